// file: tb.sv
`timescale 1ns/10ps
module tb;
  import tsv_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        tri_ready = 1'b0;
  logic [6:0]  avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest;
  logic        tri_valid;
  tsv_tri_t    tri_data;
  tsv_vertex_t m;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #5 clk = ~clk;

  tsv_setup_vertex_input uut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tri_data(tri_data), .tri_valid(tri_valid), .tri_ready(tri_ready));

  // ****************************************************************
  // Bus cycles, expectations and compares
  // ****************************************************************
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_w(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_t(tsv_tri_t e);
    while (tri_valid !== 1'b1)
      @(negedge clk);
    check_count++;
    if (tri_data !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED tri_data expected %h seen %h", e, tri_data);
    end
  endtask

  // Request held until waitrequest is low at a rising edge
  task automatic bus(logic w, logic [6:0] a, logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic acc;
    @(posedge clk);
    tri_ready <= 1'b1;
    @(posedge clk);
    tri_ready <= 1'b0;
  endtask

  task automatic nodraw;
    repeat (3) @(negedge clk);
    chk_w("tri_valid", 32'h0000_0000, 32'(tri_valid));
  endtask

  function automatic logic [31:0] wv(int k, int i);
    return {8'h42, 8'(k), 8'h00, 8'(i)};
  endfunction

  // Words 0..n-1 of vertex k, in address order
  task automatic put(int k, int n);
    for (int i = 0; i < n; i++)
      bus(1'b1, 7'(4 * i), wv(k, i));
  endtask

  // Unit-one words left unwritten follow unit zero
  function automatic tsv_vertex_t ev(int k, int n);
    tsv_vertex_t v;
    v.pix = {wv(k, 0), wv(k, 1), wv(k, 2), wv(k, 3), wv(k, 4), wv(k, 5)};
    v.tex0 = {wv(k, 5), wv(k, 6), wv(k, 7), wv(k, 8)};
    v.tex1 = (n > 9) ? {wv(k, 5), wv(k, 9), wv(k, 10), wv(k, 11)} : v.tex0;
    return v;
  endfunction

  function automatic tsv_vertex_t one(tsv_vertex_t v);
    v.tex0.inv_w = TSV_FLOAT_ONE;
    v.tex1.inv_w = TSV_FLOAT_ONE;
    return v;
  endfunction

  function automatic tsv_tri_t et(logic p, logic f, tsv_vertex_t a, b, c);
    if (p)
      return {p, f, a, b, c};
    return {p, f, one(a), one(b), one(c)};
  endfunction

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b1, TSV_OFS_SETUP, 32'hffff_ffff);
    bus(1'b0, TSV_OFS_SETUP, 32'h0);
    chk_w("setup", TSV_SETUP_MASK, rd);
    // Only the low byte lane is cleared
    avs_byteenable <= 4'h1;
    bus(1'b1, TSV_OFS_SETUP, 32'h0);
    avs_byteenable <= 4'hf;
    bus(1'b0, TSV_OFS_SETUP, 32'h0);
    chk_w("setup_be", 32'h000f_0000, rd);
    bus(1'b1, TSV_OFS_TEXMODE, 32'hffff_ffff);
    bus(1'b0, TSV_OFS_TEXMODE, 32'h0);
    chk_w("texmode", TSV_TEXMODE_MASK, rd);
    bus(1'b0, 7'h44, 32'h0);
    chk_w("unmapped", 32'h0, rd);
    bus(1'b0, TSV_OFS_RED, 32'h0);
    chk_w("red", 32'h0, rd);
    $display("Test registers done");
    bus(1'b1, TSV_OFS_SETUP, 32'h0000_00ff);
    put(1, 12);
    bus(1'b1, TSV_OFS_BEGIN, 32'h0);
    nodraw();
    put(2, 9);
    bus(1'b1, TSV_OFS_DRAW, 32'h0);
    nodraw();
    put(3, 12);
    bus(1'b1, TSV_OFS_DRAW, 32'h0);
    chk_t(et(1'b1, 1'b0, ev(1, 12), ev(2, 9), ev(3, 12)));
    put(4, 12);
    // Draw stalls behind the pending triangle until it is taken
    fork
      bus(1'b1, TSV_OFS_DRAW, 32'h0);
      acc();
    join
    chk_t(et(1'b1, 1'b0, ev(2, 9), ev(3, 12), ev(4, 12)));
    acc();
    bus(1'b0, TSV_OFS_STATUS, 32'h0);
    chk_w("status", 32'h0000_0204, rd);
    $display("Test strip done");
    bus(1'b1, TSV_OFS_SETUP, 32'h0001_00ff);
    bus(1'b1, TSV_OFS_TEXMODE, 32'h0);
    put(5, 12);
    bus(1'b1, TSV_OFS_BEGIN, 32'h0);
    put(6, 12);
    bus(1'b1, TSV_OFS_DRAW, 32'h0);
    nodraw();
    put(7, 12);
    bus(1'b1, TSV_OFS_DRAW, 32'h0);
    chk_t(et(1'b0, 1'b1, ev(5, 12), ev(6, 12), ev(7, 12)));
    acc();
    put(8, 12);
    bus(1'b1, TSV_OFS_DRAW, 32'h0);
    chk_t(et(1'b0, 1'b1, ev(5, 12), ev(7, 12), ev(8, 12)));
    acc();
    $display("Test fan done");
    bus(1'b1, TSV_OFS_SETUP, 32'h0001_0001);
    put(9, 12);
    bus(1'b1, TSV_OFS_DRAW, 32'h0);
    m = ev(8, 12);
    m.pix.red = wv(9, 0);
    m.pix.green = wv(9, 1);
    m.pix.blue = wv(9, 2);
    chk_t(et(1'b0, 1'b1, ev(5, 12), ev(8, 12), m));
    acc();
    $display("Test select done");
    tally_and_finish();
  end

  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb

// file: tsv_chk.sv
`timescale 1ns/10ps
// ****************************************************************
// Port-level checks of the vertex input block
// ****************************************************************
module tsv_chk
  import tsv_pkg::*;
(
  // Clock and reset
  input wire logic                           clk,
  input wire logic                           sys_rst,
  // Register bus
  input wire logic [tsv_pkg::TSV_ADDR_W-1:0] avs_address,
  input wire logic                           avs_read,
  input wire logic                           avs_write,
  input wire logic [tsv_pkg::TSV_DATA_W-1:0] avs_writedata,
  input wire logic [3:0]                     avs_byteenable,
  input wire logic [tsv_pkg::TSV_DATA_W-1:0] avs_readdata,
  input wire logic                           avs_waitrequest,
  // Triangle stream
  input wire tsv_pkg::tsv_tri_t              tri_data,
  input wire logic                           tri_valid,
  input wire logic                           tri_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic cmd;
  logic drw;
  assign cmd = avs_write && (avs_address == TSV_OFS_DRAW || avs_address == TSV_OFS_BEGIN);
  // Only a completed draw write may start a triangle
  assign drw = avs_write && !avs_waitrequest && avs_address == TSV_OFS_DRAW;

  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_read_answer: assert property ($rose(avs_read) |-> ##[1:2] !avs_waitrequest)
    else $error("read not answered in time");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 7'h44
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_cmd_stall: assert property (cmd && tri_valid |-> avs_waitrequest)
    else $error("command accepted while triangle pending");
  a_launch_cause: assert property ($rose(tri_valid) |-> $past(drw))
    else $error("triangle without a completed draw write");
  a_hold_stable: assert property (tri_valid && !tri_ready |=> tri_valid && $stable(tri_data))
    else $error("triangle changed before acceptance");
  a_accept_drop: assert property (tri_valid && tri_ready |=> !tri_valid)
    else $error("triangle still valid after acceptance");
  a_persp_one: assert property (tri_valid && !tri_data.persp |->
    tri_data.v0.tex0.inv_w == TSV_FLOAT_ONE && tri_data.v2.tex1.inv_w == TSV_FLOAT_ONE)
    else $error("local W not forced to one");
  a_wb_shared: assert property (tri_valid |->
    tri_data.v2.pix.inv_w == tri_data.v2.tex0.global_inv_w &&
    tri_data.v2.pix.inv_w == tri_data.v2.tex1.global_inv_w)
    else $error("global 1/W not shared");

  cover property (tri_valid && tri_ready);
  cover property (cmd && tri_valid);
  cover property (tri_valid && tri_data.fan);
endmodule // tsv_chk

bind tsv_setup_vertex_input tsv_chk chk (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tri_data(tri_data), .tri_valid(tri_valid), .tri_ready(tri_ready));

// file: tsv_pkg.sv
// ****************************************************************
// Register map, field layout and carriers
// ****************************************************************
package tsv_pkg;

  localparam int unsigned TSV_ADDR_W = 7;
  localparam int unsigned TSV_DATA_W = 32;

  // Byte addresses of the register words
  localparam logic [6:0] TSV_OFS_RED      = 7'h00;
  localparam logic [6:0] TSV_OFS_GREEN    = 7'h04;
  localparam logic [6:0] TSV_OFS_BLUE     = 7'h08;
  localparam logic [6:0] TSV_OFS_ALPHA    = 7'h0c;
  localparam logic [6:0] TSV_OFS_DEPTH    = 7'h10;
  localparam logic [6:0] TSV_OFS_GLOB_W   = 7'h14;
  localparam logic [6:0] TSV_OFS_TEX0_W   = 7'h18;
  localparam logic [6:0] TSV_OFS_TEX0_S   = 7'h1c;
  localparam logic [6:0] TSV_OFS_TEX0_T   = 7'h20;
  localparam logic [6:0] TSV_OFS_TEX1_W   = 7'h24;
  localparam logic [6:0] TSV_OFS_TEX1_S   = 7'h28;
  localparam logic [6:0] TSV_OFS_TEX1_T   = 7'h2c;
  localparam logic [6:0] TSV_OFS_DRAW     = 7'h30;
  localparam logic [6:0] TSV_OFS_BEGIN    = 7'h34;
  localparam logic [6:0] TSV_OFS_SETUP    = 7'h38;
  localparam logic [6:0] TSV_OFS_TEXMODE  = 7'h3c;
  localparam logic [6:0] TSV_OFS_STATUS   = 7'h40;

  // Setup select bits and mode bits
  localparam int unsigned TSV_SEL_RGB   = 0;
  localparam int unsigned TSV_SEL_ALPHA = 1;
  localparam int unsigned TSV_SEL_Z     = 2;
  localparam int unsigned TSV_SEL_WB    = 3;
  localparam int unsigned TSV_SEL_W0    = 4;
  localparam int unsigned TSV_SEL_ST0   = 5;
  localparam int unsigned TSV_SEL_W1    = 6;
  localparam int unsigned TSV_SEL_ST1   = 7;
  localparam int unsigned TSV_SEL_W     = 8;
  localparam int unsigned TSV_FAN_BIT   = 16;
  localparam int unsigned TSV_PERSP_BIT = 0;

  // Reset values and writable masks
  localparam logic [31:0] TSV_FIELD_RST    = 32'h0000_0000;
  localparam logic [31:0] TSV_SETUP_RST    = 32'h0000_0000;
  localparam logic [31:0] TSV_TEXMODE_RST  = 32'h0000_0000;
  localparam logic [31:0] TSV_SETUP_MASK   = 32'h000f_00ff;
  localparam logic [31:0] TSV_TEXMODE_MASK = 32'h7fff_ffff;
  localparam logic [31:0] TSV_FLOAT_ONE    = 32'h3f80_0000;

  // Status word layout
  localparam int unsigned TSV_ST_VALID = 0;
  localparam int unsigned TSV_ST_STATE = 1;
  localparam int unsigned TSV_ST_FAN   = 3;
  localparam int unsigned TSV_ST_COUNT = 8;

  typedef enum logic [1:0] {
    TSV_STRIP_IDLE = 2'b00,
    TSV_STRIP_ONE  = 2'b01,
    TSV_STRIP_TWO  = 2'b10
  } tsv_strip_state_t;

  typedef struct packed {
    logic [31:0] red;
    logic [31:0] green;
    logic [31:0] blue;
    logic [31:0] alpha;
    logic [31:0] depth;
    logic [31:0] inv_w;
  } tsv_pix_vtx_t;

  typedef struct packed {
    logic [31:0] global_inv_w;
    logic [31:0] inv_w;
    logic [31:0] s_over_w;
    logic [31:0] t_over_w;
  } tsv_tex_vtx_t;

  typedef struct packed {
    tsv_pix_vtx_t pix;
    tsv_tex_vtx_t tex0;
    tsv_tex_vtx_t tex1;
  } tsv_vertex_t;

  typedef struct packed {
    logic        persp;
    logic        fan;
    tsv_vertex_t v0;
    tsv_vertex_t v1;
    tsv_vertex_t v2;
  } tsv_tri_t;

endpackage

// file: tsv_setup_vertex_input.sv
`timescale 1ns/10ps
// How it works
// - Red, green and blue of the current vertex are separate writable words.
// - Alpha of the current vertex is its own writable word.
// - Every vertex word is held as a raw 32-bit single float.
// - Depth word becomes the vertex Z carried into setup.
// - Global 1/W goes to the pixel pipeline and both texture units.
// - Unit-zero local 1/W is loaded into every texture unit.
// - Unit-zero S/W is loaded into every texture unit.
// - Unit-zero T/W is loaded into every texture unit.
// - Unit-one 1/W word overrides only the second unit.
// - Unit-one S/W word overrides only the second unit.
// - Unit-one T/W word overrides only the second unit.
// - A draw command write in the two-vertex state launches a triangle from retained plus current vertex.
// - A begin command latches the current vertex as first of a new strip.
// - Begin never emits a triangle, it only restarts strip state.
// - Perspective bit set passes S/W, T/W and local 1/W unchanged.
// - Perspective bit clear forces local W to one, linear S and T.
// - First triangle leaves only after begin and two draws.
// - Fan mode keeps the first vertex and each draw replaces only the older of the other two.
// - Setup mode bit 16 chooses strip (0) or fan (1).
// - Unselected parameters repeat the previous vertex value.
module tsv_setup_vertex_input #(
  parameter int unsigned TRI_CNT_W = 24
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  // Avalon-MM register slave
  input  wire logic [tsv_pkg::TSV_ADDR_W-1:0]    avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [tsv_pkg::TSV_DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [tsv_pkg::TSV_DATA_W-1:0]    avs_readdata,
  output logic                                   avs_waitrequest,
  // Triangle stream to the rasterizer
  output tsv_pkg::tsv_tri_t                      tri_data,
  output logic                                   tri_valid,
  input  wire logic                              tri_ready
);
  import tsv_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] apply_be(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[8*i +: 8] = new_val[8*i +: 8];
    end
    apply_be = res;
  endfunction

  // Linear mode: texture units see W as 1.0
  function automatic tsv_vertex_t persp_fix(input tsv_vertex_t v, input logic persp);
    tsv_vertex_t r;
    r = v;
    if (!persp)
    begin
      r.tex0.inv_w = TSV_FLOAT_ONE;
      r.tex1.inv_w = TSV_FLOAT_ONE;
    end
    persp_fix = r;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tsv_vertex_t         cur_vtx;
  tsv_vertex_t         merged_vtx;
  tsv_vertex_t         last_vtx;
  tsv_vertex_t         slot_a;
  tsv_vertex_t         slot_b;
  tsv_strip_state_t    strip_state;
  logic [31:0]         setup_mode;
  logic [31:0]         tex_mode;
  logic [31:0]         next_readdata;
  logic [TRI_CNT_W-1:0] tri_count;
  logic                req;
  logic                wr_acc;
  logic                is_cmd;
  logic                stall;
  logic                draw_cmd;
  logic                begin_cmd;
  logic                launch;
  logic                fan_mode;
  logic                persp_on;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  assign req      = avs_read | avs_write;
  assign wr_acc   = avs_write & ~avs_waitrequest;
  assign is_cmd   = (avs_address == TSV_OFS_DRAW) | (avs_address == TSV_OFS_BEGIN);
  // Commands wait while a triangle is still unaccepted downstream
  assign stall    = avs_write & is_cmd & tri_valid;
  assign draw_cmd  = wr_acc & (avs_address == TSV_OFS_DRAW);
  assign begin_cmd = wr_acc & (avs_address == TSV_OFS_BEGIN);
  assign fan_mode = setup_mode[TSV_FAN_BIT];
  assign persp_on = tex_mode[TSV_PERSP_BIT];

  // One-cycle acknowledge window, then back to busy
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else if (avs_waitrequest && req && !stall)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // Vertex words are write-only and read back zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      TSV_OFS_SETUP:   next_readdata = setup_mode;
      TSV_OFS_TEXMODE: next_readdata = tex_mode;
      TSV_OFS_STATUS:
      begin
        next_readdata[TSV_ST_VALID]      = tri_valid;
        next_readdata[TSV_ST_STATE +: 2] = strip_state;
        next_readdata[TSV_ST_FAN]        = fan_mode;
        next_readdata[TSV_ST_COUNT +: TRI_CNT_W] = tri_count;
      end
      default:         next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_waitrequest && avs_read)
      avs_readdata <= next_readdata;
  end

  // ****************************************************************
  // Pixel-side vertex words
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cur_vtx.pix <= '0;
    else if (wr_acc)
    begin
      case (avs_address)
        TSV_OFS_RED:    cur_vtx.pix.red <= apply_be(cur_vtx.pix.red, avs_writedata,
                                                    avs_byteenable);
        TSV_OFS_GREEN:  cur_vtx.pix.green <= apply_be(cur_vtx.pix.green, avs_writedata,
                                                      avs_byteenable);
        TSV_OFS_BLUE:   cur_vtx.pix.blue <= apply_be(cur_vtx.pix.blue, avs_writedata,
                                                     avs_byteenable);
        TSV_OFS_ALPHA:  cur_vtx.pix.alpha <= apply_be(cur_vtx.pix.alpha, avs_writedata,
                                                      avs_byteenable);
        TSV_OFS_DEPTH:  cur_vtx.pix.depth <= apply_be(cur_vtx.pix.depth, avs_writedata,
                                                      avs_byteenable);
        TSV_OFS_GLOB_W: cur_vtx.pix.inv_w <= apply_be(cur_vtx.pix.inv_w, avs_writedata,
                                                      avs_byteenable);
        default:        cur_vtx.pix <= cur_vtx.pix;
      endcase
    end
  end

  // ****************************************************************
  // Texture-side vertex words
  // ****************************************************************
  // Unit-zero words broadcast; unit-one words written later override
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur_vtx.tex0 <= '0;
      cur_vtx.tex1 <= '0;
    end
    else if (wr_acc)
    begin
      case (avs_address)
        TSV_OFS_GLOB_W:
        begin
          cur_vtx.tex0.global_inv_w <= apply_be(cur_vtx.tex0.global_inv_w, avs_writedata,
                                                avs_byteenable);
          cur_vtx.tex1.global_inv_w <= apply_be(cur_vtx.tex1.global_inv_w, avs_writedata,
                                                avs_byteenable);
        end
        TSV_OFS_TEX0_W:
        begin
          cur_vtx.tex0.inv_w <= apply_be(cur_vtx.tex0.inv_w, avs_writedata,
                                         avs_byteenable);
          cur_vtx.tex1.inv_w <= apply_be(cur_vtx.tex1.inv_w, avs_writedata,
                                         avs_byteenable);
        end
        TSV_OFS_TEX0_S:
        begin
          cur_vtx.tex0.s_over_w <= apply_be(cur_vtx.tex0.s_over_w, avs_writedata,
                                            avs_byteenable);
          cur_vtx.tex1.s_over_w <= apply_be(cur_vtx.tex1.s_over_w, avs_writedata,
                                            avs_byteenable);
        end
        TSV_OFS_TEX0_T:
        begin
          cur_vtx.tex0.t_over_w <= apply_be(cur_vtx.tex0.t_over_w, avs_writedata,
                                            avs_byteenable);
          cur_vtx.tex1.t_over_w <= apply_be(cur_vtx.tex1.t_over_w, avs_writedata,
                                            avs_byteenable);
        end
        TSV_OFS_TEX1_W:
          cur_vtx.tex1.inv_w <= apply_be(cur_vtx.tex1.inv_w, avs_writedata,
                                         avs_byteenable);
        TSV_OFS_TEX1_S:
          cur_vtx.tex1.s_over_w <= apply_be(cur_vtx.tex1.s_over_w, avs_writedata,
                                            avs_byteenable);
        TSV_OFS_TEX1_T:
          cur_vtx.tex1.t_over_w <= apply_be(cur_vtx.tex1.t_over_w, avs_writedata,
                                            avs_byteenable);
        default:
        begin
          cur_vtx.tex0 <= cur_vtx.tex0;
          cur_vtx.tex1 <= cur_vtx.tex1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Mode registers
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      setup_mode <= TSV_SETUP_RST;
    else if (wr_acc && avs_address == TSV_OFS_SETUP)
      setup_mode <= apply_be(setup_mode, avs_writedata, avs_byteenable)
                    & TSV_SETUP_MASK;
  end

  // Only the perspective bit steers this block; bits 1 to 30 are stored, bit 31 is dropped
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tex_mode <= TSV_TEXMODE_RST;
    else if (wr_acc && avs_address == TSV_OFS_TEXMODE)
      tex_mode <= apply_be(tex_mode, avs_writedata, avs_byteenable)
                  & TSV_TEXMODE_MASK;
  end

  // ****************************************************************
  // Vertex merge and strip tracking
  // ****************************************************************
  tsv_vertex_merge u_merge (
    .cur_vtx    (cur_vtx),
    .prev_vtx   (last_vtx),
    .select     (setup_mode[TSV_SEL_W-1:0]),
    .merged_vtx (merged_vtx)
  );

  tsv_strip_ctrl u_strip (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .begin_cmd (begin_cmd),
    .draw_cmd  (draw_cmd),
    .fan_mode  (fan_mode),
    .new_vtx   (merged_vtx),
    .state     (strip_state),
    .slot_a    (slot_a),
    .slot_b    (slot_b),
    .last_vtx  (last_vtx),
    .launch    (launch)
  );

  // ****************************************************************
  // Triangle output
  // ****************************************************************
  // Stall guarantees the slot is empty whenever launch fires
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tri_valid <= 1'b0;
      tri_data  <= '0;
    end
    else if (launch)
    begin
      tri_valid      <= 1'b1;
      tri_data.persp <= persp_on;
      tri_data.fan   <= fan_mode;
      tri_data.v0    <= persp_fix(slot_a, persp_on);
      tri_data.v1    <= persp_fix(slot_b, persp_on);
      tri_data.v2    <= persp_fix(merged_vtx, persp_on);
    end
    else if (tri_ready)
      tri_valid <= 1'b0;
  end

  // Wraps silently at full scale
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tri_count <= '0;
    else if (launch)
      tri_count <= tri_count + 1'b1;
  end

endmodule // tsv_setup_vertex_input

// file: tsv_strip_ctrl.sv
`timescale 1ns/10ps
module tsv_strip_ctrl (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Commands
  input  wire logic                      begin_cmd,
  input  wire logic                      draw_cmd,
  input  wire logic                      fan_mode,
  input  wire tsv_pkg::tsv_vertex_t      new_vtx,
  // Retained vertices
  output tsv_pkg::tsv_strip_state_t      state,
  output tsv_pkg::tsv_vertex_t           slot_a,
  output tsv_pkg::tsv_vertex_t           slot_b,
  output tsv_pkg::tsv_vertex_t           last_vtx,
  output logic                           launch
);
  import tsv_pkg::*;

  // A draw without a preceding begin is dropped
  assign launch = draw_cmd & (state == TSV_STRIP_TWO);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= TSV_STRIP_IDLE;
    else if (begin_cmd)
      state <= TSV_STRIP_ONE;
    else if (draw_cmd)
    begin
      case (state)
        TSV_STRIP_IDLE: state <= TSV_STRIP_IDLE;
        TSV_STRIP_ONE:  state <= TSV_STRIP_TWO;
        TSV_STRIP_TWO:  state <= TSV_STRIP_TWO;
        default:        state <= TSV_STRIP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot_a   <= '0;
      slot_b   <= '0;
      last_vtx <= '0;
    end
    else if (begin_cmd)
    begin
      slot_a   <= new_vtx;
      last_vtx <= new_vtx;
    end
    else if (draw_cmd && state != TSV_STRIP_IDLE)
    begin
      last_vtx <= new_vtx;
      slot_b   <= new_vtx;
      // Fan keeps its hub, strip retires the oldest
      if (state == TSV_STRIP_TWO && !fan_mode)
        slot_a <= slot_b;
      // Fan leaves slot_a untouched here
      if (state == TSV_STRIP_TWO && fan_mode)
        slot_a <= slot_a;
    end
  end

endmodule // tsv_strip_ctrl

// file: tsv_vertex_merge.sv
`timescale 1ns/10ps
module tsv_vertex_merge (
  // Vertex sources
  input  wire tsv_pkg::tsv_vertex_t  cur_vtx,
  input  wire tsv_pkg::tsv_vertex_t  prev_vtx,
  input  wire logic [tsv_pkg::TSV_SEL_W-1:0] select,
  // Merged vertex
  output tsv_pkg::tsv_vertex_t       merged_vtx
);
  import tsv_pkg::*;

  function automatic logic [31:0] pick(input logic sel, input logic [31:0] a,
                                       input logic [31:0] b);
    pick = sel ? a : b;
  endfunction

  // Unselected parameters repeat the previous vertex
  always_comb
  begin
    merged_vtx.pix.red    = pick(select[TSV_SEL_RGB], cur_vtx.pix.red, prev_vtx.pix.red);
    merged_vtx.pix.green  = pick(select[TSV_SEL_RGB], cur_vtx.pix.green, prev_vtx.pix.green);
    merged_vtx.pix.blue   = pick(select[TSV_SEL_RGB], cur_vtx.pix.blue, prev_vtx.pix.blue);
    merged_vtx.pix.alpha  = pick(select[TSV_SEL_ALPHA], cur_vtx.pix.alpha, prev_vtx.pix.alpha);
    merged_vtx.pix.depth  = pick(select[TSV_SEL_Z], cur_vtx.pix.depth, prev_vtx.pix.depth);
    merged_vtx.pix.inv_w  = pick(select[TSV_SEL_WB], cur_vtx.pix.inv_w, prev_vtx.pix.inv_w);
    merged_vtx.tex0.global_inv_w = pick(select[TSV_SEL_WB], cur_vtx.tex0.global_inv_w,
                                        prev_vtx.tex0.global_inv_w);
    merged_vtx.tex1.global_inv_w = pick(select[TSV_SEL_WB], cur_vtx.tex1.global_inv_w,
                                        prev_vtx.tex1.global_inv_w);
    merged_vtx.tex0.inv_w = pick(select[TSV_SEL_W0], cur_vtx.tex0.inv_w, prev_vtx.tex0.inv_w);
    merged_vtx.tex0.s_over_w = pick(select[TSV_SEL_ST0], cur_vtx.tex0.s_over_w,
                                    prev_vtx.tex0.s_over_w);
    merged_vtx.tex0.t_over_w = pick(select[TSV_SEL_ST0], cur_vtx.tex0.t_over_w,
                                    prev_vtx.tex0.t_over_w);
    merged_vtx.tex1.inv_w = pick(select[TSV_SEL_W1], cur_vtx.tex1.inv_w, prev_vtx.tex1.inv_w);
    merged_vtx.tex1.s_over_w = pick(select[TSV_SEL_ST1], cur_vtx.tex1.s_over_w,
                                    prev_vtx.tex1.s_over_w);
    merged_vtx.tex1.t_over_w = pick(select[TSV_SEL_ST1], cur_vtx.tex1.t_over_w,
                                    prev_vtx.tex1.t_over_w);
  end

endmodule // tsv_vertex_merge
